// file: cce_pkg.sv
// Shared constants and types for the call and clear execution block.
// Assumes a single 125 MHz core clock and a plain strobe register port.
package cce_pkg;

    localparam int CCE_AW   = 8;
    localparam int CCE_DW   = 16;
    localparam int CCE_PCW  = 11;
    localparam int CCE_IW   = 12;

    // Register offsets
    localparam logic [7:0] CCE_OFF_INSTR     = 8'h00;
    localparam logic [7:0] CCE_OFF_STATUS    = 8'h04;
    localparam logic [7:0] CCE_OFF_WREG      = 8'h08;
    localparam logic [7:0] CCE_OFF_PC        = 8'h0c;
    localparam logic [7:0] CCE_OFF_STACK_TOP = 8'h10;
    localparam logic [7:0] CCE_OFF_WDOG_CTRL = 8'h14;
    localparam logic [7:0] CCE_OFF_WDOG_CNT  = 8'h18;
    localparam logic [7:0] CCE_OFF_FILE_ADDR = 8'h1c;
    localparam logic [7:0] CCE_OFF_FILE_DATA = 8'h20;

    // Status field positions
    localparam int CCE_ST_Z       = 2;
    localparam int CCE_ST_PWRDN_N = 3;
    localparam int CCE_ST_TMOUT_N = 4;
    localparam int CCE_ST_PG_L    = 5;
    localparam int CCE_ST_PG_H    = 6;

    // Values after reset
    localparam logic [7:0] CCE_STATUS_RST  = 8'h18;
    localparam logic       CCE_PSA_RST     = 1'b1;
    localparam logic [7:0] CCE_ZERO8       = 8'h00;

    // Instruction encodings
    localparam logic [3:0]  CCE_OP_CALL     = 4'h9;
    localparam logic [6:0]  CCE_OP_CLR_FILE = 7'h03;
    localparam logic [11:0] CCE_OP_CLR_WORK = 12'h040;
    localparam logic [11:0] CCE_OP_CLR_WDOG = 12'h004;

    // Watchdog tick timing
    localparam int CCE_CLK_NS   = 8;
    localparam int CCE_TICK_NS  = 1000;
    localparam int CCE_TICK_CYC = (CCE_TICK_NS + CCE_CLK_NS - 1) / CCE_CLK_NS;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } cce_bus_req_t;

    typedef enum logic [0:0] {
        CCE_IDLE  = 1'b0,
        CCE_FLUSH = 1'b1
    } cce_state_t;

endpackage : cce_pkg

// file: cce_stack.sv
// Return stack of fixed depth built as a shift register.
// Assumes pushes come from the executing core on the same clock.
`timescale 1ns/1ps
module cce_stack
    import cce_pkg::*;
#(
    parameter int DEPTH = 2
)(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    // Push side
    input  wire logic               push,
    input  wire logic [CCE_PCW-1:0] push_data,
    // Top entry
    output logic      [CCE_PCW-1:0] stack_top
);
    initial
    begin
        if (DEPTH < 1)
            $error("cce_stack: DEPTH must be at least 1");
    end

    logic [CCE_PCW-1:0] entry [DEPTH];

    // oldest entry overwritten
    // Oldest falls off the bottom; no overflow flag is kept
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_ent
            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                    entry[gi] <= '0;
                else if (push)
                    entry[gi] <= (gi == 0) ? push_data : entry[(gi == 0) ? 0 : gi - 1];
            end
        end
    endgenerate

    assign stack_top = entry[0];

endmodule : cce_stack

// file: cce_file_regs.sv
// General file registers, 32 bytes of flip-flops, one write port.
// Assumes the core never writes and clears in the same cycle.
`timescale 1ns/1ps
module cce_file_regs
    import cce_pkg::*;
#(
    parameter int NREG = 32
)(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // Write port
    input  wire logic              we,
    input  wire logic [4:0]        waddr,
    input  wire logic [7:0]        wdata,
    // Read port
    input  wire logic [4:0]        raddr,
    output logic      [7:0]        rdata
);
    initial
    begin
        if (NREG < 1 || NREG > 32)
            $error("cce_file_regs: NREG out of range");
    end

    logic [7:0] mem [NREG];

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_reg
            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                    mem[gi] <= CCE_ZERO8;
                else if (we && waddr == 5'(gi))
                    mem[gi] <= wdata;
            end
        end
    endgenerate

    // Unpopulated addresses read as zero
    assign rdata = (int'(raddr) < NREG) ? mem[raddr] : CCE_ZERO8;

endmodule : cce_file_regs

// file: cce_exec.sv
// Execution of call, clear-file, clear-working and watchdog clear.
// Assumes one instruction is handed over per register write.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module cce_exec
    import cce_pkg::*;
#(
    parameter int STACK_DEPTH = 2,
    parameter int TICK_CYC    = CCE_TICK_CYC
)(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // Register port
    input  wire cce_bus_req_t      bus_req,
    output logic [CCE_DW-1:0]      rd_data,
    // Status
    output logic                   exec_busy,
    output logic                   wdog_expired
);
    initial
    begin
        if (TICK_CYC < 1 || TICK_CYC > 65535)
            $error("cce_exec: TICK_CYC out of range");
    end

    cce_state_t         state;
    logic [CCE_PCW-1:0] pc;
    logic [7:0]         status;
    logic [7:0]         wreg;
    logic [7:0]         watchdog_counter;
    logic [7:0]         prescaler;
    logic               psa;
    logic [4:0]         file_sel;
    logic [15:0]        tick_cnt;
    logic               tick;
    logic [CCE_PCW-1:0] stack_top;
    logic [7:0]         file_rdata;
    logic               fr_we;
    logic [4:0]         fr_waddr;
    logic [7:0]         fr_wdata;

    // Request decode
    logic        wr_hit_instr;
    logic [11:0] instr;
    logic        do_call;
    logic        do_clear_file;
    logic        do_clear_work;
    logic        do_clear_wdog;
    logic        wdog_step;
    logic        wdog_wrap;

    assign instr        = bus_req.wdata[CCE_IW-1:0];
    assign wr_hit_instr = bus_req.wr && bus_req.addr == CCE_OFF_INSTR
                          && state == CCE_IDLE;
    assign do_call      = wr_hit_instr && instr[11:8] == CCE_OP_CALL;
    assign do_clear_file = wr_hit_instr && instr[11:5] == CCE_OP_CLR_FILE;
    assign do_clear_work = wr_hit_instr && instr == CCE_OP_CLR_WORK;
    assign do_clear_wdog = wr_hit_instr && instr == CCE_OP_CLR_WDOG;

    // Instruction cycle sequencer
    // Busy while the prefetched word is discarded after a call
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            state <= CCE_IDLE;
        else
        begin
            case (state)
                CCE_IDLE:
                    if (do_call)
                        state <= CCE_FLUSH;
                CCE_FLUSH:
                    state <= CCE_IDLE;
                default:
                    state <= CCE_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            exec_busy <= 1'b0;
        else
            exec_busy <= do_call;
    end

    // Program counter
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            pc <= '0;
        else if (do_call)
            pc <= {status[CCE_ST_PG_H:CCE_ST_PG_L], 1'b0, instr[7:0]};
        else if (wr_hit_instr)
            pc <= pc + 11'h001;
        else if (bus_req.wr && bus_req.addr == CCE_OFF_PC && state == CCE_IDLE)
            pc <= bus_req.wdata[CCE_PCW-1:0];
    end

    cce_stack #(
        .DEPTH     (STACK_DEPTH)
    ) u_stack (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .push      (do_call),
        .push_data (pc + 11'h001),
        .stack_top (stack_top)
    );

    assign fr_we    = do_clear_file
                      || (bus_req.wr && bus_req.addr == CCE_OFF_FILE_DATA);
    assign fr_waddr = do_clear_file ? instr[4:0] : file_sel;
    assign fr_wdata = do_clear_file ? CCE_ZERO8 : bus_req.wdata[7:0];

    cce_file_regs #(
        .NREG     (32)
    ) u_file (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .we       (fr_we),
        .waddr    (fr_waddr),
        .wdata    (fr_wdata),
        .raddr    (file_sel),
        .rdata    (file_rdata)
    );

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            file_sel <= '0;
        else if (bus_req.wr && bus_req.addr == CCE_OFF_FILE_ADDR)
            file_sel <= bus_req.wdata[4:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            wreg <= CCE_ZERO8;
        else if (do_clear_work)
            wreg <= CCE_ZERO8;
        else if (bus_req.wr && bus_req.addr == CCE_OFF_WREG)
            wreg <= bus_req.wdata[7:0];
    end

    // Status register
    // A watchdog clear suppresses a wrap in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            status <= CCE_STATUS_RST;
        else
        begin
            if (bus_req.wr && bus_req.addr == CCE_OFF_STATUS)
            begin
                status[CCE_ST_PG_H:CCE_ST_PG_L] <= bus_req.wdata[CCE_ST_PG_H:CCE_ST_PG_L];
                status[CCE_ST_Z]                <= bus_req.wdata[CCE_ST_Z];
            end
            if (do_clear_file || do_clear_work)
                status[CCE_ST_Z] <= 1'b1;
            if (do_clear_wdog)
            begin
                status[CCE_ST_TMOUT_N] <= 1'b1;
                status[CCE_ST_PWRDN_N] <= 1'b1;
            end
            if (wdog_wrap)
                status[CCE_ST_TMOUT_N] <= 1'b0;
        end
    end

    // Watchdog tick divider
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end
        else if (tick_cnt == 16'(TICK_CYC - 1))
        begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    // Prescaler stretches the tick only while the watchdog owns it
    assign wdog_step = tick && (!psa || prescaler == 8'hff);
    assign wdog_wrap = wdog_step && watchdog_counter == 8'hff && !do_clear_wdog;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            psa <= CCE_PSA_RST;
        else if (bus_req.wr && bus_req.addr == CCE_OFF_WDOG_CTRL)
            psa <= bus_req.wdata[0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            watchdog_counter <= CCE_ZERO8;
        else if (do_clear_wdog)
            watchdog_counter <= CCE_ZERO8;
        else if (wdog_step)
            watchdog_counter <= watchdog_counter + 8'h01;
    end

    // prescaler cleared if owned
    // The first timer is not modelled, so its prescaler simply holds
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            prescaler <= CCE_ZERO8;
        else if (do_clear_wdog && psa)
            prescaler <= CCE_ZERO8;
        else if (tick && psa && !do_clear_wdog)
            prescaler <= prescaler + 8'h01;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            wdog_expired <= 1'b0;
        else
            wdog_expired <= wdog_wrap;
    end

    // Read port, unmapped addresses read zero
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            rd_data <= '0;
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                CCE_OFF_INSTR:     rd_data <= {15'h0000, state == CCE_FLUSH};
                CCE_OFF_STATUS:    rd_data <= {8'h00, status};
                CCE_OFF_WREG:      rd_data <= {8'h00, wreg};
                CCE_OFF_PC:        rd_data <= {5'h00, pc};
                CCE_OFF_STACK_TOP: rd_data <= {5'h00, stack_top};
                CCE_OFF_WDOG_CTRL: rd_data <= {15'h0000, psa};
                CCE_OFF_WDOG_CNT:  rd_data <= {prescaler, watchdog_counter};
                CCE_OFF_FILE_ADDR: rd_data <= {11'h000, file_sel};
                CCE_OFF_FILE_DATA: rd_data <= {8'h00, file_rdata};
                default:           rd_data <= '0;
            endcase
        end
        else
            rd_data <= '0;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_call_push: assert property (do_call |=> stack_top == $past(pc) + 11'h001)
        else $error("call did not push PC plus one");
    a_call_literal: assert property (do_call |=> pc[7:0] == $past(instr[7:0]))
        else $error("call literal not in PC low byte");
    a_call_page: assert property (
        do_call |=> pc[10:9] == $past(status[CCE_ST_PG_H:CCE_ST_PG_L]))
        else $error("call page bits wrong");
    a_call_bit8: assert property (do_call |=> !pc[8] ##1 !pc[8] || $changed(pc))
        else $error("call left PC bit 8 set");
    a_call_cycles: assert property (
        do_call |=> exec_busy && !wr_hit_instr ##1 !exec_busy && state == CCE_IDLE)
        else $error("call did not take two cycles");
    a_call_flags: assert property (
        do_call && !wdog_wrap |=> $stable(status))
        else $error("call changed status");
    a_file_zero: assert property (
        do_clear_file |-> fr_we && fr_wdata == 8'h00 ##1 status[CCE_ST_Z])
        else $error("clear file did not zero and set Z");
    a_file_addr: assert property (do_clear_file |-> fr_waddr == instr[4:0])
        else $error("clear file address not from low bits");
    a_work_zero: assert property (
        do_clear_work |=> wreg == 8'h00 && status[CCE_ST_Z])
        else $error("clear working failed");
    a_wdog_clear: assert property (do_clear_wdog |=> watchdog_counter == 8'h00)
        else $error("watchdog counter not cleared");
    a_ps_owned: assert property (do_clear_wdog && psa |=> prescaler == 8'h00)
        else $error("owned prescaler not cleared");
    a_ps_kept: assert property (do_clear_wdog && !psa |=> $stable(prescaler))
        else $error("timer prescaler disturbed");
    a_flags_set: assert property (
        do_clear_wdog |=> status[CCE_ST_TMOUT_N] && status[CCE_ST_PWRDN_N])
        else $error("timeout or powerdown flag not set");

    c_call: cover property (do_call ##2 do_clear_file);
    c_clear_owned: cover property (do_clear_wdog && psa && prescaler != 8'h00);
    c_wdog_wrap: cover property (wdog_wrap);
    c_clear_work: cover property (do_clear_work ##1 do_call);

endmodule : cce_exec

// file: tb.sv
// Self-checking bench for the call and clear execution block.
// Drives the register port itself; watchdog tick shortened to one cycle.
`timescale 1ns/1ps
module tb;
    import cce_pkg::*;

    logic              core_clk;
    logic              rst_b;
    cce_bus_req_t      bus_req;
    logic [CCE_DW-1:0] rd_data;
    logic              exec_busy;
    logic              wdog_expired;
    int                err_total;
    int                checked;
    int                seed;
    int                i;
    int                n;
    logic [15:0]       rv;
    logic [15:0]       sv;
    logic [10:0]       pc0;
    logic [7:0]        kk;
    logic [7:0]        p1;
    logic [1:0]        pg;
    logic [4:0]        fa;

    cce_exec #(
        .STACK_DEPTH  (2),
        .TICK_CYC     (1)
    ) cce_exec_inst (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .bus_req      (bus_req),
        .rd_data      (rd_data),
        .exec_busy    (exec_busy),
        .wdog_expired (wdog_expired)
    );

    always #4 core_clk = ~core_clk;

    task automatic stop_test;
        begin
            $display("Comparisons %0d, mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask : stop_test

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        begin
            checked++;
            if (got !== exp)
            begin
                err_total++;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp);
        begin
            checked++;
            if (got !== exp)
            begin
                err_total++;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask : chk_flag

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        begin
            @(posedge core_clk);
            bus_req.addr  <= a;
            bus_req.wdata <= d;
            bus_req.wr    <= 1'b1;
            @(posedge core_clk);
            bus_req.wr    <= 1'b0;
            #1;
        end
    endtask : bus_wr

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
        begin
            @(posedge core_clk);
            bus_req.addr <= a;
            bus_req.rd   <= 1'b1;
            @(posedge core_clk);
            bus_req.rd   <= 1'b0;
            #1;
            d = rd_data;
        end
    endtask : bus_rd

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        begin
            bus_rd(a, rv);
            chk_val(rv & m, e);
        end
    endtask : rd_chk

    task automatic exec(input logic [11:0] w);
        begin
            bus_wr(CCE_OFF_INSTR, {4'h0, w});
        end
    endtask : exec

    // Polls until the prescaler sits mid-range and the counter has moved
    task automatic wait_pre;
        begin
            n = 0;
            do
            begin
                bus_rd(CCE_OFF_WDOG_CNT, rv);
                n++;
            end
            while ((rv[15:8] < 8'h40 || rv[15:8] > 8'hc0 || rv[7:0] == 8'h00) && n < 3000);
            if (n >= 3000)
            begin
                err_total++;
                stop_test();
            end
        end
    endtask : wait_pre

    initial
    begin
        core_clk  = 1'b0;
        rst_b     = 1'b0;
        bus_req   = '0;
        err_total = 0;
        checked   = 0;
        seed      = 32'h1a71;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk(CCE_OFF_STATUS, 16'hffff, {8'h00, CCE_STATUS_RST});
        @(posedge core_clk);
        #1;
        chk_val(rd_data, 16'h0000);
        rd_chk(CCE_OFF_WDOG_CTRL, 16'h0001, 16'h0001);
        rd_chk(8'h3c, 16'hffff, 16'h0000);
        for (i = 0; i < 24; i++)
        begin
            pc0 = 11'($random(seed));
            kk  = 8'($random(seed));
            pg  = 2'($random(seed));
            if (i == 0)
            begin
                pc0 = 11'h7ff;
                kk  = 8'hff;
            end
            sv = {9'h0, pg, 2'b11, 1'($random(seed)), 2'b00};
            bus_wr(CCE_OFF_PC, {5'h0, pc0});
            bus_wr(CCE_OFF_STATUS, sv);
            exec({CCE_OP_CALL, kk});
            chk_flag(exec_busy, 1'b1);
            @(posedge core_clk);
            #1;
            chk_flag(exec_busy, 1'b0);
            rd_chk(CCE_OFF_PC, 16'h07ff, {5'h0, pg, 1'b0, kk});
            rd_chk(CCE_OFF_STACK_TOP, 16'h07ff, {5'h0, pc0 + 11'h1});
            rd_chk(CCE_OFF_STATUS, 16'h007c, sv);
        end
        bus_wr(CCE_OFF_PC, 16'h0123);
        @(posedge core_clk);
        bus_req.addr  <= CCE_OFF_INSTR;
        bus_req.wdata <= {4'h0, CCE_OP_CALL, 8'h5a};
        bus_req.wr    <= 1'b1;
        @(posedge core_clk);
        bus_req.wdata <= {4'h0, CCE_OP_CALL, 8'ha5};
        @(posedge core_clk);
        bus_req.wr    <= 1'b0;
        #1;
        rd_chk(CCE_OFF_PC, 16'h07ff, {5'h0, pg, 1'b0, 8'h5a});
        rd_chk(CCE_OFF_STACK_TOP, 16'h07ff, 16'h0124);
        for (i = 0; i < 6; i++)
        begin
            fa = (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : 5'($random(seed));
            bus_wr(CCE_OFF_FILE_ADDR, {11'h0, fa ^ 5'h01});
            bus_wr(CCE_OFF_FILE_DATA, 16'h00c3);
            bus_wr(CCE_OFF_FILE_ADDR, {11'h0, fa});
            bus_wr(CCE_OFF_FILE_DATA, {8'h0, 8'($random(seed)) | 8'h01});
            bus_wr(CCE_OFF_STATUS, 16'h0000);
            exec({4'h0, CCE_OP_CLR_FILE, fa});
            rd_chk(CCE_OFF_FILE_DATA, 16'h00ff, 16'h0000);
            rd_chk(CCE_OFF_STATUS, 16'h0004, 16'h0004);
            bus_wr(CCE_OFF_FILE_ADDR, {11'h0, fa ^ 5'h01});
            rd_chk(CCE_OFF_FILE_DATA, 16'h00ff, 16'h00c3);
        end
        bus_wr(CCE_OFF_WREG, 16'h005a);
        bus_wr(CCE_OFF_STATUS, 16'h0000);
        exec(CCE_OP_CLR_WORK);
        rd_chk(CCE_OFF_WREG, 16'h00ff, 16'h0000);
        rd_chk(CCE_OFF_STATUS, 16'h0004, 16'h0004);
        // prescaler kept when the timer owns it
        wait_pre();
        bus_wr(CCE_OFF_WDOG_CTRL, 16'h0000);
        bus_rd(CCE_OFF_WDOG_CNT, rv);
        p1 = rv[15:8];
        exec(CCE_OP_CLR_WDOG);
        bus_rd(CCE_OFF_WDOG_CNT, rv);
        chk_flag(rv[15:8] >= p1 && rv[15:8] >= 8'h40, 1'b1);
        chk_flag(rv[7:0] < 8'h08, 1'b1);
        n = 0;
        while (wdog_expired !== 1'b1 && n < 600)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 600)
        begin
            err_total++;
            stop_test();
        end
        rd_chk(CCE_OFF_STATUS, 16'h0010, 16'h0000);
        exec(CCE_OP_CLR_WDOG);
        rd_chk(CCE_OFF_STATUS, 16'h0018, 16'h0018);
        bus_rd(CCE_OFF_WDOG_CNT, rv);
        chk_flag(rv[7:0] < 8'h08, 1'b1);
        // both cleared when the watchdog owns it
        bus_wr(CCE_OFF_WDOG_CTRL, 16'h0001);
        wait_pre();
        exec(CCE_OP_CLR_WDOG);
        bus_rd(CCE_OFF_WDOG_CNT, rv);
        chk_val({8'h00, rv[7:0]}, 16'h0000);
        chk_flag(rv[15:8] < 8'h08, 1'b1);
        stop_test();
    end
endmodule : tb
